// File: rtl/xfer_bus_master.sv
// Purpose: Bus master end of the interlocked read and write transfers.
// Assumes: Bus grant already held; requester issues one request at a time.
// Notes: Bus-busy is held while holdBus is set or a read-pause is pending.
`default_nettype none
// Contract
// - Drive address and control only under bus-busy
// - Slaves decode address; selected one answers
// - Read strobe after 150 ns, reply negated
// - Slave puts data before reply strobe
// - Wait 75 ns after reply, capture
// - Tail deskew 75 ns, then release
// - Slave drops data before dropping reply
// - Keep bus-busy between chained transfers
// - Timeout drops strobe, sets error flag
// - Write strobe after 150 ns valid
// - Write waits 150 ns after reply negation
// - Slave captures write data by reply
// - Write drops strobe on reply
// - Write data removed with address (code drops it with the strobe on reply, 8 cycles before the address)
// - Slave negates reply after strobe negation
// - Word and byte writes share handshake
// - Read-pause followed by same-word write
module xfer_bus_master (
  input wire logic sys_clk,
  input wire logic srst,
  xfer_bus_if.master bus,
  input wire logic reqValid,
  input wire xfer_bus_pkg::xfer_kind_t reqKind,
  input wire logic [xfer_bus_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [xfer_bus_pkg::DATA_W-1:0] reqData,
  input wire logic holdBus,
  input wire logic errClear,
  output logic reqReady,
  output logic done,
  output logic [xfer_bus_pkg::DATA_W-1:0] rdData,
  output logic timeoutErr
);
  // Sequencer states and the counters that time each phase.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_WAIT_REPLY = 3'b010,
    ST_DESKEW = 3'b011,
    ST_TAIL = 3'b100
  } mstate_t;
  mstate_t state;
  logic [xfer_bus_pkg::CNT_W-1:0] setupCnt;
  logic [xfer_bus_pkg::CNT_W-1:0] replyLowCnt;
  logic [xfer_bus_pkg::CNT_W-1:0] phaseCnt;
  logic replyMeta, replySync;
  logic pausePending;
  logic [xfer_bus_pkg::ADDR_W-1:0] pauseAddr;
  logic timedOut;
  logic isWrite;

  // Returns true for the two write kinds, which share one handshake.
  function automatic logic kindIsWrite(input xfer_bus_pkg::xfer_kind_t k);
    return k[1];
  endfunction : kindIsWrite

  // True on the last cycle of the reply wait, when the timeout runs out.
  function automatic logic replyWaitExpired(input logic [xfer_bus_pkg::CNT_W-1:0] cnt);
    return cnt == 12'(xfer_bus_pkg::REPLY_TIMEOUT_CYC - 1);
  endfunction : replyWaitExpired

  // The reply strobe comes from the other party; two flip-flops first.
  always_ff @(posedge sys_clk) begin
    replyMeta <= bus.slaveSyncReply;
    replySync <= replyMeta;
  end

  // Counts how long the reply has been seen negated, saturating.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      replyLowCnt <= '0;
    end else if (replySync) begin
      replyLowCnt <= '0;
    end else if (replyLowCnt != 12'(xfer_bus_pkg::REPLY_DESKEW_CYC)) begin
      replyLowCnt <= replyLowCnt + 12'h001;
    end
  end

  // The kind on the control lines steers the handshake while a cycle runs.
  assign isWrite = kindIsWrite(xfer_bus_pkg::xfer_kind_t'(bus.ctrlLines));

  // Ready in idle once the request line has been low for a cycle.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reqReady <= 1'b0;
    end else begin
      reqReady <= (state == ST_IDLE) && !reqValid;
    end
  end

  // Main handshake sequencer.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= ST_IDLE;
      bus.busBusy <= 1'b0;
      bus.addrLines <= 18'h0_0000;
      bus.ctrlLines <= 2'h0;
      bus.addrValid <= 1'b0;
      bus.masterSyncStrobe <= 1'b0;
      bus.masterData <= 16'h0000;
      bus.masterDataOe <= 1'b0;
      setupCnt <= '0;
      phaseCnt <= '0;
      done <= 1'b0;
      rdData <= 16'h0000;
      timedOut <= 1'b0;
      pausePending <= 1'b0;
      pauseAddr <= 18'h0_0000;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Read-pause must be followed by a write to the same word.
          if (reqValid && reqReady && (!pausePending ||
              (kindIsWrite(reqKind) && reqAddr[17:1] == pauseAddr[17:1]))) begin
            bus.busBusy <= 1'b1;
            bus.addrLines <= reqAddr;
            bus.ctrlLines <= reqKind;
            bus.addrValid <= 1'b1;
            bus.masterData <= reqData;
            bus.masterDataOe <= kindIsWrite(reqKind); // Data with address.
            setupCnt <= '0;
            timedOut <= 1'b0;
            state <= ST_SETUP;
          end else if (!holdBus && !pausePending) begin
            bus.busBusy <= 1'b0;
          end
        end
        ST_SETUP: begin
          // Front deskew first; a write also waits for the reply to stay low.
          if (setupCnt != 12'(xfer_bus_pkg::FRONT_DESKEW_CYC)) begin
            setupCnt <= setupCnt + 12'h001;
          end else if (!replySync && (!isWrite ||
              replyLowCnt == 12'(xfer_bus_pkg::REPLY_DESKEW_CYC))) begin
            bus.masterSyncStrobe <= 1'b1;
            phaseCnt <= '0;
            state <= ST_WAIT_REPLY;
          end
        end
        ST_WAIT_REPLY: begin
          // A reply ends a write at once; a read goes on to the data deskew.
          phaseCnt <= phaseCnt + 12'h001;
          if (replySync) begin
            phaseCnt <= '0;
            if (isWrite) begin
              bus.masterSyncStrobe <= 1'b0;
              bus.masterDataOe <= 1'b0;
              state <= ST_TAIL;
            end else begin
              state <= ST_DESKEW;
            end
          end else if (replyWaitExpired(phaseCnt)) begin
            bus.masterSyncStrobe <= 1'b0;
            bus.masterDataOe <= 1'b0;
            rdData <= bus.dataLines;
            timedOut <= 1'b1;
            phaseCnt <= '0;
            state <= ST_TAIL;
          end
        end
        ST_DESKEW: begin
          // Let the data lines settle before the read data is strobed.
          phaseCnt <= phaseCnt + 12'h001;
          if (phaseCnt == 12'(xfer_bus_pkg::DATA_DESKEW_CYC - 1)) begin
            rdData <= bus.dataLines;
            bus.masterSyncStrobe <= 1'b0;
            phaseCnt <= '0;
            state <= ST_TAIL;
          end
        end
        ST_TAIL: begin
          // Address stays valid until every slave has seen the strobe fall.
          phaseCnt <= phaseCnt + 12'h001;
          if (phaseCnt == 12'(xfer_bus_pkg::TAIL_DESKEW_CYC - 1)) begin
            bus.addrValid <= 1'b0;
            bus.ctrlLines <= 2'h0;
            bus.addrLines <= 18'h0_0000;
            pausePending <= (bus.ctrlLines == xfer_bus_pkg::READ_PAUSE_CYCLE) && !timedOut;
            pauseAddr <= bus.addrLines;
            done <= 1'b1;
            state <= ST_IDLE; // Busy held while holdBus or pause pending.
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Sticky timeout flag; a new timeout wins over a clear.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      timeoutErr <= 1'b0;
    end else if (state == ST_WAIT_REPLY && !replySync &&
        replyWaitExpired(phaseCnt)) begin
      timeoutErr <= 1'b1;
    end else if (errClear) begin
      timeoutErr <= 1'b0;
    end
  end
endmodule : xfer_bus_master
`default_nettype wire

// File: rtl/xfer_bus_pkg.sv
// Purpose: Shared constants and types for the interlocked data-transfer bus.
// Assumes: One 100 MHz clock shared by both ends.
// Notes: Deskew counts are derived from their times in ns, the timeout count from its time in us.
`default_nettype none
package xfer_bus_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 16;
  // Front-end deskew, data deskew, tail-end deskew and reply deskew in ns.
  localparam int unsigned FRONT_DESKEW_NS = 150;
  localparam int unsigned DATA_DESKEW_NS = 75;
  localparam int unsigned TAIL_DESKEW_NS = 75;
  localparam int unsigned REPLY_DESKEW_NS = 150;
  localparam int unsigned REPLY_TIMEOUT_US = 20;
  // Least times round up to whole cycles.
  localparam int unsigned FRONT_DESKEW_CYC = (FRONT_DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_DESKEW_CYC = (DATA_DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TAIL_DESKEW_CYC = (TAIL_DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REPLY_DESKEW_CYC = (REPLY_DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Timeout is a longest time and rounds down.
  localparam int unsigned REPLY_TIMEOUT_CYC = (REPLY_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 12;
  // Slave answer delay after the master strobe, in cycles.
  localparam int unsigned SLAVE_DELAY_CYC = 2;
  // Transfer-type control encoding on the control lines.
  typedef enum logic [1:0] {
    READ_WORD_CYCLE = 2'b00,
    READ_PAUSE_CYCLE = 2'b01,
    WRITE_WORD_CYCLE = 2'b10,
    WRITE_BYTE_CYCLE = 2'b11
  } xfer_kind_t;
endpackage : xfer_bus_pkg
`default_nettype wire

// File: rtl/xfer_bus_if.sv
// Purpose: Shared bus wires between master and slave ends.
// Assumes: Data lines are shared; each end has its own enable.
// Notes: Resolved data is the driving end's value, else zero.
`default_nettype none
interface xfer_bus_if;
  logic busBusy;
  logic [xfer_bus_pkg::ADDR_W-1:0] addrLines;
  logic [1:0] ctrlLines;
  logic addrValid;
  logic masterSyncStrobe;
  logic slaveSyncReply;
  logic [xfer_bus_pkg::DATA_W-1:0] masterData;
  logic masterDataOe;
  logic [xfer_bus_pkg::DATA_W-1:0] slaveData;
  logic slaveDataOe;
  logic [xfer_bus_pkg::DATA_W-1:0] dataLines;
  // The data wire takes whichever end drives it.
  assign dataLines = masterDataOe ? masterData : (slaveDataOe ? slaveData : '0);
  modport master (output busBusy, output addrLines, output ctrlLines, output addrValid,
    output masterSyncStrobe, output masterData, output masterDataOe,
    input slaveSyncReply, input dataLines);
  modport slave (input busBusy, input addrLines, input ctrlLines, input addrValid,
    input masterSyncStrobe, output slaveSyncReply, output slaveData, output slaveDataOe,
    input dataLines);
endinterface : xfer_bus_if
`default_nettype wire

// File: rtl/xfer_bus_slave.sv
// Purpose: Addressed slave end: answers the master strobe with the reply strobe.
// Assumes: A small flip-flop word store at a base address.
// Notes: Byte writes use the low address bit to pick the lane.
`default_nettype none
module xfer_bus_slave #(
  parameter logic [17:0] BASE_ADDR = 18'h0_0000,
  parameter int unsigned WORDS = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  xfer_bus_if.slave bus,
  output logic writeSeen,
  output logic [xfer_bus_pkg::DATA_W-1:0] lastWrite
);
  localparam int unsigned IDX_W = $clog2(WORDS);
  logic strobeMeta, strobeSync, aValidMeta, aValidSync;
  logic [xfer_bus_pkg::DATA_W-1:0] mem [WORDS];
  logic [1:0] waitCnt;
  logic selected;
  logic [IDX_W-1:0] idx;
  // Bus strobes come from another party, so pass two flip-flops first.
  always_ff @(posedge sys_clk) begin
    strobeMeta <= bus.masterSyncStrobe;
    strobeSync <= strobeMeta;
    aValidMeta <= bus.addrValid;
    aValidSync <= aValidMeta;
  end
  // Address decode selects this device only in its window.
  assign selected = aValidSync &&
    (bus.addrLines[17:IDX_W+1] == BASE_ADDR[17:IDX_W+1]);
  assign idx = bus.addrLines[IDX_W:1];
  // Handshake: answer after a short delay, release on strobe negation.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus.slaveSyncReply <= 1'b0;
      bus.slaveDataOe <= 1'b0;
      bus.slaveData <= 16'h0000;
      waitCnt <= 2'h0;
      writeSeen <= 1'b0;
      lastWrite <= 16'h0000;
      for (int i = 0; i < WORDS; i++) mem[i] <= 16'h0000;
    end else begin
      writeSeen <= 1'b0;
      if (strobeSync && selected && !bus.slaveSyncReply) begin
        if (waitCnt != 2'(xfer_bus_pkg::SLAVE_DELAY_CYC)) begin
          waitCnt <= waitCnt + 2'h1;
        end else if (!bus.ctrlLines[1]) begin
          if (!bus.slaveDataOe) begin
            bus.slaveData <= mem[idx];
            bus.slaveDataOe <= 1'b1; // Data first, reply next cycle.
          end else begin
            bus.slaveSyncReply <= 1'b1;
          end
        end else begin
          // Capture write data no later than the reply.
          if (bus.ctrlLines == xfer_bus_pkg::WRITE_BYTE_CYCLE) begin
            if (bus.addrLines[0]) mem[idx][15:8] <= bus.dataLines[15:8];
            else mem[idx][7:0] <= bus.dataLines[7:0];
          end else begin
            mem[idx] <= bus.dataLines;
          end
          lastWrite <= bus.dataLines;
          writeSeen <= 1'b1;
          bus.slaveSyncReply <= 1'b1;
        end
      end else if (!strobeSync && bus.slaveSyncReply) begin
        waitCnt <= 2'h0;
        if (bus.slaveDataOe) bus.slaveDataOe <= 1'b0; // Drop data first.
        else bus.slaveSyncReply <= 1'b0;
      end
    end
  end
endmodule : xfer_bus_slave
`default_nettype wire

// File: verif/async_bus_data_transfer_asserts.sv
// Purpose: Checker for the handshake between the master and slave ends.
// Assumes: One clock; srst is synchronous and active high.
// Notes: Cycle figures follow the package deskew counts.
`default_nettype none
module async_bus_data_transfer_asserts (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic busBusy,
  input wire logic [1:0] ctrlLines,
  input wire logic addrValid,
  input wire logic masterSyncStrobe,
  input wire logic slaveSyncReply,
  input wire logic masterDataOe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Longest strobe span: the reply timeout plus a small margin.
  localparam int unsigned STROBE_LIMIT = xfer_bus_pkg::REPLY_TIMEOUT_CYC + 10;
  logic [11:0] strobeHighCnt;
  logic [11:0] addrHighCnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Counts how long the master strobe has stood high, saturating.
  always_ff @(posedge sys_clk) begin
    if (srst || !masterSyncStrobe) begin
      strobeHighCnt <= 12'h000;
    end else if (strobeHighCnt != 12'hFFF) begin
      strobeHighCnt <= strobeHighCnt + 12'h001;
    end
  end
  // Counts how long address and control have stood valid, saturating.
  always_ff @(posedge sys_clk) begin
    if (srst || !addrValid) begin
      addrHighCnt <= 12'h000;
    end else if (addrHighCnt != 12'hFFF) begin
      addrHighCnt <= addrHighCnt + 12'h001;
    end
  end
  // Strobe order, deskew spacing and bus hold across a transfer.
  property p_busy; addrValid |-> busBusy; endproperty
  a_busy: assert property (p_busy) else $error("address without busy");
  property p_front; $rose(masterSyncStrobe) |-> !slaveSyncReply &&
    addrHighCnt >= 12'(xfer_bus_pkg::FRONT_DESKEW_CYC); endproperty
  a_front: assert property (p_front) else $error("strobe too early");
  property p_gap; $rose(masterSyncStrobe) && ctrlLines[1] |-> !$past(slaveSyncReply, 15);
  endproperty
  a_gap: assert property (p_gap) else $error("reply gap short");
  property p_rd; $rose(slaveSyncReply) && !ctrlLines[1] |->
    masterSyncStrobe [*8] ##[1:5] !masterSyncStrobe; endproperty
  a_rd: assert property (p_rd) else $error("read deskew wrong");
  property p_wr; $rose(slaveSyncReply) && ctrlLines[1] |-> ##[1:4] !masterSyncStrobe;
  endproperty
  a_wr: assert property (p_wr) else $error("write strobe held");
  property p_tail; $fell(masterSyncStrobe) |-> addrValid [*8]; endproperty
  a_tail: assert property (p_tail) else $error("tail deskew short");
  property p_tmo; strobeHighCnt <= 12'(STROBE_LIMIT); endproperty
  a_tmo: assert property (p_tmo) else $error("strobe never ends");
  property p_doe; masterDataOe |-> addrValid && ctrlLines[1]; endproperty
  a_doe: assert property (p_doe) else $error("data outlives address");
  property p_pause; $fell(addrValid) && $past(ctrlLines) == 2'b01 |-> busBusy [*3];
  endproperty
  a_pause: assert property (p_pause) else $error("busy dropped after pause");
  property p_rel; $fell(slaveSyncReply) |-> !$past(masterSyncStrobe); endproperty
  a_rel: assert property (p_rel) else $error("reply dropped early");
  c_read: cover property ($rose(masterSyncStrobe) && ctrlLines == 2'b00);
  c_byte: cover property ($rose(masterSyncStrobe) && ctrlLines == 2'b11);
  c_pause: cover property ($fell(addrValid) && $past(ctrlLines) == 2'b01);
endmodule : async_bus_data_transfer_asserts
`default_nettype wire

// File: verif/async_bus_data_transfer_tb.sv
// Purpose: Self-checking bench joining the master and slave ends.
// Assumes: Slave store sits at address zero; other addresses stay unanswered.
// Notes: The timeout case waits the full reply timeout.
`default_nettype none
module async_bus_data_transfer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic reqValid = 1'b0;
  xfer_bus_pkg::xfer_kind_t reqKind = xfer_bus_pkg::READ_WORD_CYCLE;
  logic [17:0] reqAddr = 18'h0_0000;
  logic [15:0] reqData = 16'h0000;
  logic holdBus = 1'b0;
  logic errClear = 1'b0;
  logic reqReady, done, timeoutErr, writeSeen;
  logic [15:0] rdData, lastWrite;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int writes = 0;
  xfer_bus_if bus ();
  xfer_bus_master xfer_bus_master_i (.sys_clk(sys_clk), .srst(srst), .bus(bus.master),
    .reqValid(reqValid), .reqKind(reqKind), .reqAddr(reqAddr), .reqData(reqData),
    .holdBus(holdBus), .errClear(errClear), .reqReady(reqReady), .done(done),
    .rdData(rdData), .timeoutErr(timeoutErr));
  xfer_bus_slave xfer_bus_slave_i (.sys_clk(sys_clk), .srst(srst), .bus(bus.slave),
    .writeSeen(writeSeen), .lastWrite(lastWrite));
  async_bus_data_transfer_asserts async_bus_data_transfer_asserts_i (.sys_clk(sys_clk),
    .srst(srst), .busBusy(bus.busBusy), .ctrlLines(bus.ctrlLines), .addrValid(bus.addrValid),
    .masterSyncStrobe(bus.masterSyncStrobe), .slaveSyncReply(bus.slaveSyncReply),
    .masterDataOe(bus.masterDataOe));
  // The clock toggles every half period of 10 ns.
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // A hung run is cut short and counted as a mismatch.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      close_out();
    end
  end
  // Counts the slave's capture pulses over the run.
  always @(posedge sys_clk) begin
    if (writeSeen === 1'b1) begin
      writes++;
    end
  end
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  // Runs one request to its done pulse; values are read as sampled at the edge.
  task automatic issue(input xfer_bus_pkg::xfer_kind_t k, input logic [17:0] a,
      input logic [15:0] d, input logic h);
    int n;
    n = 0;
    reqKind <= k;
    reqAddr <= a;
    reqData <= d;
    holdBus <= h;
    while (reqReady !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    reqValid <= 1'b1;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(16'h0001, {15'h0000, done});
  endtask : issue
  task automatic t_write_read();
    issue(xfer_bus_pkg::WRITE_WORD_CYCLE, 18'h0_0002, 16'hA5C3, 1'b1);
    chk(16'hA5C3, lastWrite);
    repeat (2) @(posedge sys_clk);
    chk(16'h0001, {15'h0000, bus.busBusy});
    issue(xfer_bus_pkg::READ_WORD_CYCLE, 18'h0_0002, 16'h0000, 1'b0);
    chk(16'hA5C3, rdData);
    repeat (2) @(posedge sys_clk);
    chk(16'h0000, {15'h0000, bus.busBusy});
  endtask : t_write_read
  task automatic t_byte();
    issue(xfer_bus_pkg::WRITE_WORD_CYCLE, 18'h0_0004, 16'h1234, 1'b0);
    issue(xfer_bus_pkg::WRITE_BYTE_CYCLE, 18'h0_0005, 16'hABAB, 1'b0);
    issue(xfer_bus_pkg::WRITE_BYTE_CYCLE, 18'h0_0004, 16'hCDCD, 1'b0);
    issue(xfer_bus_pkg::READ_WORD_CYCLE, 18'h0_0004, 16'h0000, 1'b0);
    chk(16'hABCD, rdData);
  endtask : t_byte
  task automatic t_pause();
    issue(xfer_bus_pkg::READ_PAUSE_CYCLE, 18'h0_0004, 16'h0000, 1'b0);
    chk(16'hABCD, rdData);
    repeat (2) @(posedge sys_clk);
    chk(16'h0001, {15'h0000, bus.busBusy});
    issue(xfer_bus_pkg::WRITE_WORD_CYCLE, 18'h0_0005, 16'h0F0F, 1'b0);
    chk(16'h0F0F, lastWrite);
    chk(16'h0005, 16'(writes));
  endtask : t_pause
  task automatic t_timeout();
    issue(xfer_bus_pkg::READ_WORD_CYCLE, 18'h0_0100, 16'h0000, 1'b0);
    chk(16'h0001, {15'h0000, timeoutErr});
    chk(16'h0000, rdData);
    errClear <= 1'b1;
    @(posedge sys_clk);
    errClear <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(16'h0000, {15'h0000, timeoutErr});
    chk(16'h0001, {15'h0000, reqReady});
  endtask : t_timeout
  // Reset, then each scenario in turn.
  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_write_read();
    t_byte();
    t_pause();
    t_timeout();
    close_out();
  end
endmodule : async_bus_data_transfer_tb
`default_nettype wire
